// ==== design/ddr_hs_pkg.sv ====
// constants shared by the controller end and the user end of the handshake
// assumes a single 100 MHz main clock shared by both ends
package ddr_hs_pkg;
	localparam int          DATA_W           = 16;          // memory data width n
	localparam int          USER_W           = 2 * DATA_W;  // single-rate user word
	localparam int          ADDR_W           = 24;          // row, column and bank
	localparam int          CLK_PERIOD_PS    = 10000;       // 100 MHz main clock
	localparam int          REFRESH_PERIOD_PS = 7700000;    // 7.7 us refresh spacing
	localparam int          REFRESH_INTERVAL_COUNT = REFRESH_PERIOD_PS / CLK_PERIOD_PS;
	localparam int          RFC_COUNT        = 8;           // refresh cycle time in clocks
	localparam int          INIT_COUNT       = 16;          // init sequence length in clocks
	localparam int          PRECHARGE_COUNT  = 2;           // precharge after burst end
	localparam int          POST_REFRESH_GAP = 3;           // clocks after done pulse
	localparam int          TERMINATE_WAIT   = 15;          // user reacts to refresh in 15..20
	localparam int          CNT_W            = 16;          // width of the timer, refresh and gap counters
	localparam logic [2:0]  CMD_NOP          = 3'h0;        // no command
	localparam logic [2:0]  CMD_INIT         = 3'h2;        // initialise memory
	localparam logic [2:0]  CMD_WRITE        = 3'h4;        // write burst
	localparam logic [2:0]  CMD_READ         = 3'h6;        // read burst
	localparam logic [1:0]  BL_2             = 2'h1;        // burst length two
	localparam logic [1:0]  BL_4             = 2'h2;        // burst length four
	localparam logic [1:0]  BL_8             = 2'h3;        // burst length eight

	// clocks of burst terminate per burst length
	function automatic logic [3:0] terminate_clocks(input logic [1:0] bl);
		case (bl)
			BL_2:    terminate_clocks = 4'h1;
			BL_8:    terminate_clocks = 4'h4;
			default: terminate_clocks = 4'h2;
		endcase
	endfunction : terminate_clocks
endpackage : ddr_hs_pkg

// ==== design/ddr_hs_if.sv ====
// interface joining the controller end and the user end
// assumes both ends run on the same main clock
`timescale 1ns/1ps
interface ddr_hs_if;
	import ddr_hs_pkg::*;
	logic [2:0]        command;                 // command code, user driven
	logic [ADDR_W-1:0] address;                 // transfer address
	logic              burst_terminate;         // ends the burst
	logic [USER_W-1:0] write_data;              // user write word
	logic              command_acknowledge;     // command in progress
	logic              initialization_complete; // memory ready
	logic              refresh_request;         // refresh pending
	logic              refresh_complete_pulse;  // one clock at refresh end
	logic [USER_W-1:0] read_data_to_user;       // user read word
	logic              read_data_valid;         // read word valid

	modport controller (
		input  command, address, burst_terminate, write_data,
		output command_acknowledge, initialization_complete, refresh_request,
		output refresh_complete_pulse, read_data_to_user, read_data_valid
	);
	modport user (
		output command, address, burst_terminate, write_data,
		input  command_acknowledge, initialization_complete, refresh_request,
		input  refresh_complete_pulse, read_data_to_user, read_data_valid
	);
endinterface : ddr_hs_if

// ==== design/ddr_hs_controller.sv ====
// controller end: acknowledge, init flag, refresh request and done pulse
// assumes synchronous user inputs; memory pins are a plain half-word port
`timescale 1ns/1ps

// What this block does
// - user holds terminate 1/2/4 clocks per length
// - bursts stay in one row; reinit next row
// - acknowledge high during transfer; wait its fall
// - raise init complete after init sequence
// - refresh request each 7.7us until issued
// - user terminates within 15-20 clocks of request
// - interval taken from refresh interval count
// - done pulse one clock after tRFC
// - next command three clocks after done
// - commands presented and sampled on main clock
// - acknowledge next clock, after refresh if busy
// - user word split into two memory halves
module ddr_hs_controller
	import ddr_hs_pkg::*;
#(
	parameter int REFRESH_COUNT = REFRESH_INTERVAL_COUNT  // clocks between requests
) (
	input  wire logic              clk_sys,        // main clock
	input  wire logic              nrst,           // async reset, active low
	ddr_hs_if.controller           hs,             // user side handshake
	input  wire logic [1:0]        burst_length,   // selected burst length
	input  wire logic [DATA_W-1:0] mem_read_half,  // half word from memory
	output logic [DATA_W-1:0]      mem_write_half, // half word to memory
	output logic                   mem_refresh_cmd, // auto-refresh issued
	output logic                   mem_precharge   // precharge issued
);
	typedef enum logic [5:0] {
		ST_IDLE  = 6'h01,  // waiting for a command
		ST_INIT  = 6'h02,  // init sequence running
		ST_XFER  = 6'h04,  // burst in progress
		ST_PRE   = 6'h08,  // precharge after terminate
		ST_RFC   = 6'h10,  // waiting out tRFC
		ST_GAP   = 6'h20   // hold-off after done pulse
	} state_e;

	typedef struct packed {
		state_e            state;       // control state
		logic [CNT_W-1:0]  timer;       // per state timer
		logic [CNT_W-1:0]  ref_timer;   // refresh interval counter
		logic [2:0]        pend_cmd;    // command waiting for refresh
		logic              ack;         // command acknowledge
		logic              init_done;   // init complete flag
		logic              ref_req;     // refresh request
		logic              ref_done;    // refresh done pulse
		logic              refresh;     // refresh command strobe
		logic              precharge;   // precharge strobe
		logic              phase;       // which half goes out
		logic [USER_W-1:0] wr_word;     // latched write word
		logic [DATA_W-1:0] wr_half;     // half word out
		logic [DATA_W-1:0] rd_low;      // first read half
		logic [USER_W-1:0] rd_word;     // assembled read word
		logic              rd_valid;    // read word valid
	} state_s;

	state_s cur;       // registered state
	state_s next_cur;  // next state

	// refresh due when interval counter expires
	logic refresh_due;
	assign refresh_due = (cur.ref_timer == CNT_W'(REFRESH_COUNT - 1));

	// next state logic
	always_comb begin
		next_cur           = cur;
		next_cur.ref_done  = 1'b0;
		next_cur.refresh   = 1'b0;
		next_cur.precharge = 1'b0;
		next_cur.rd_valid  = 1'b0;
		// interval counter runs freely once memory is initialised
		if (cur.init_done) begin
			next_cur.ref_timer = refresh_due ? '0 : cur.ref_timer + 1'b1;
			if (refresh_due) begin
				next_cur.ref_req = 1'b1;
			end
		end
		// double-rate split and assembly of words
		next_cur.phase = ~cur.phase;
		if (cur.ack && cur.state == ST_XFER) begin
			if (!cur.phase) begin
				next_cur.wr_word = hs.write_data;
				next_cur.wr_half = hs.write_data[DATA_W-1:0];
				next_cur.rd_low  = mem_read_half;
			end else begin
				next_cur.wr_half  = cur.wr_word[USER_W-1:DATA_W];
				next_cur.rd_word  = {mem_read_half, cur.rd_low};
				next_cur.rd_valid = (cur.pend_cmd == CMD_READ);
			end
		end
		case (cur.state)
			ST_IDLE: begin
				// commands sampled on the main clock edge
				if (hs.command == CMD_INIT) begin
					next_cur.state     = ST_INIT;
					next_cur.timer     = '0;
					next_cur.init_done = 1'b0;
					next_cur.ref_req   = 1'b0;
					next_cur.ref_timer = '0;
				end else if (cur.ref_req) begin
					// refresh first; a waiting command is held off
					next_cur.refresh = 1'b1;
					next_cur.ref_req = refresh_due;
					next_cur.state   = ST_RFC;
					next_cur.timer   = '0;
					if (cur.init_done && (hs.command == CMD_WRITE || hs.command == CMD_READ)) begin
						next_cur.pend_cmd = hs.command;
					end
				end else if (cur.init_done &&
						(hs.command == CMD_WRITE || hs.command == CMD_READ)) begin
					next_cur.ack      = 1'b1;
					next_cur.pend_cmd = hs.command;
					next_cur.state    = ST_XFER;
					next_cur.timer    = '0;
				end
				// other codes fall through unchanged: reserved, no action
			end
			ST_INIT: begin
				next_cur.timer = cur.timer + 1'b1;
				if (cur.timer == CNT_W'(INIT_COUNT - 1)) begin
					next_cur.init_done = 1'b1;
					next_cur.state     = ST_IDLE;
				end
			end
			ST_XFER: begin
				// terminate must stand its full length before precharge
				if (hs.burst_terminate) begin
					next_cur.timer = cur.timer + 1'b1;
					if (cur.timer[3:0] == terminate_clocks(burst_length) - 4'h1) begin
						next_cur.state     = ST_PRE;
						next_cur.timer     = '0;
						next_cur.precharge = 1'b1;
					end
				end else begin
					next_cur.timer = '0;
				end
			end
			ST_PRE: begin
				next_cur.timer = cur.timer + 1'b1;
				if (cur.timer == CNT_W'(PRECHARGE_COUNT - 1)) begin
					next_cur.ack      = 1'b0;
					next_cur.pend_cmd = CMD_NOP;
					next_cur.state    = ST_IDLE;
				end
			end
			ST_RFC: begin
				next_cur.timer = cur.timer + 1'b1;
				if (cur.timer == CNT_W'(RFC_COUNT - 1)) begin
					next_cur.ref_done = 1'b1;
					next_cur.state    = ST_GAP;
					next_cur.timer    = '0;
				end
			end
			ST_GAP: begin
				// hold-off, then a command waiting on the refresh is acknowledged
				next_cur.timer = cur.timer + 1'b1;
				if (cur.timer == CNT_W'(POST_REFRESH_GAP - 1)) begin
					if (cur.pend_cmd != CMD_NOP) begin
						next_cur.ack   = 1'b1;
						next_cur.state = ST_XFER;
						next_cur.timer = '0;
					end else begin
						next_cur.state = ST_IDLE;
					end
				end
			end
			default: begin
				next_cur.state = ST_IDLE;
			end
		endcase
	end

	// state register
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			cur       <= '0;
			cur.state <= ST_IDLE;
		end else begin
			cur <= next_cur;
		end
	end

	// outputs straight from flip-flops
	assign hs.command_acknowledge     = cur.ack;
	assign hs.initialization_complete = cur.init_done;
	assign hs.refresh_request         = cur.ref_req;
	assign hs.refresh_complete_pulse  = cur.ref_done;
	assign hs.read_data_to_user       = cur.rd_word;
	assign hs.read_data_valid         = cur.rd_valid;
	assign mem_write_half             = cur.wr_half;
	assign mem_refresh_cmd            = cur.refresh;
	assign mem_precharge              = cur.precharge;
endmodule : ddr_hs_controller

// ==== design/ddr_hs_user.sv ====
// user end: issues init, then bursts, obeying acknowledge and refresh hold-offs
// assumes the controller end shares the main clock
`timescale 1ns/1ps
module ddr_hs_user
	import ddr_hs_pkg::*;
(
	input  wire logic              clk_sys,      // main clock
	input  wire logic              nrst,         // async reset, active low
	ddr_hs_if.user                 hs,           // controller side handshake
	input  wire logic [1:0]        burst_length, // selected burst length
	input  wire logic              req_valid,    // user wants a burst
	input  wire logic              req_write,    // 1 write, 0 read
	input  wire logic [ADDR_W-1:0] req_addr,     // burst start address
	input  wire logic [USER_W-1:0] req_wdata,    // write word
	input  wire logic [3:0]        req_beats,    // addresses in the burst
	output logic                   req_ready,    // request taken
	output logic [USER_W-1:0]      rsp_rdata,    // read word
	output logic                   rsp_valid     // read word valid
);
	typedef enum logic [5:0] {
		U_RESET = 6'h01,  // send init
		U_WINIT = 6'h02,  // wait init complete
		U_IDLE  = 6'h04,  // ready for a burst
		U_WACK  = 6'h08,  // command held, wait acknowledge
		U_BURST = 6'h10,  // addresses flowing
		U_TERM  = 6'h20   // terminate strobe, wait ack low
	} ustate_e;

	typedef struct packed {
		ustate_e           state;    // control state
		logic [2:0]        cmd;      // command driven
		logic [ADDR_W-1:0] addr;     // address driven
		logic [USER_W-1:0] wdata;    // write word driven
		logic              term;     // terminate strobe
		logic [3:0]        beats;    // addresses left
		logic [3:0]        cnt;      // clock counter
		logic [CNT_W-1:0]  gap;      // hold-off after refresh done
		logic              ready;    // request taken
		logic [USER_W-1:0] rdata;    // read word
		logic              rvalid;   // read valid
	} ustate_s;

	ustate_s cur;       // registered state
	ustate_s next_cur;  // next state

	// next state logic
	always_comb begin
		next_cur        = cur;
		next_cur.ready  = 1'b0;
		next_cur.rvalid = hs.read_data_valid;
		next_cur.rdata  = hs.read_data_to_user;
		if (cur.gap != '0) begin
			next_cur.gap = cur.gap - 1'b1;
		end
		if (hs.refresh_complete_pulse) begin
			next_cur.gap = CNT_W'(POST_REFRESH_GAP);
		end
		case (cur.state)
			U_RESET: begin
				next_cur.cmd   = CMD_INIT;
				next_cur.state = U_WINIT;
			end
			U_WINIT: begin
				next_cur.cmd = CMD_NOP;
				if (hs.initialization_complete) begin
					next_cur.state = U_IDLE;
				end
			end
			U_IDLE: begin
				// no command while ack high, refresh pending or in hold-off
				if (req_valid && !hs.command_acknowledge && !hs.refresh_request &&
						cur.gap == '0 && !hs.refresh_complete_pulse) begin
					next_cur.cmd   = req_write ? CMD_WRITE : CMD_READ;
					next_cur.addr  = req_addr;
					next_cur.wdata = req_wdata;
					next_cur.beats = (req_beats == 4'h0) ? 4'h1 : req_beats;
					next_cur.ready = 1'b1;
					next_cur.state = U_WACK;
					next_cur.cnt   = 4'h0;
				end
			end
			U_WACK: begin
				if (hs.command_acknowledge) begin
					next_cur.cnt = cur.cnt + 4'h1;
					if (cur.cnt == 4'h2) begin
						next_cur.beats = cur.beats - 4'h1;
						next_cur.cnt   = 4'h0;
						next_cur.state = U_BURST;
					end
				end
			end
			U_BURST: begin
				// addresses stay in one row; a refresh ends the burst early
				if (cur.beats == 4'h0 || hs.refresh_request) begin
					next_cur.term  = 1'b1;
					next_cur.cnt   = 4'h0;
					next_cur.state = U_TERM;
				end else begin
					next_cur.cnt = cur.cnt + 4'h1;
					if (cur.cnt == terminate_clocks(burst_length) - 4'h1) begin
						next_cur.addr  = cur.addr + ADDR_W'(1);
						next_cur.beats = cur.beats - 4'h1;
						next_cur.cnt   = 4'h0;
					end
				end
			end
			U_TERM: begin
				next_cur.cnt = cur.cnt + 4'h1;
				if (cur.cnt == terminate_clocks(burst_length) - 4'h1) begin
					next_cur.term = 1'b0;
					next_cur.cmd  = CMD_NOP;
				end
				if (!cur.term && !hs.command_acknowledge) begin
					next_cur.state = U_IDLE;
				end
			end
			default: begin
				next_cur.state = U_RESET;
			end
		endcase
	end

	// state register; commands change on the main clock edge
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			cur       <= '0;
			cur.state <= U_RESET;
		end else begin
			cur <= next_cur;
		end
	end

	assign hs.command         = cur.cmd;
	assign hs.address         = cur.addr;
	assign hs.write_data      = cur.wdata;
	assign hs.burst_terminate = cur.term;
	assign req_ready          = cur.ready;
	assign rsp_rdata          = cur.rdata;
	assign rsp_valid          = cur.rvalid;
endmodule : ddr_hs_user

// ==== bench/ddr_hs_props.sv ====
// checker for the handshake joining the controller end and the user end
// assumes one main clock; sees only the interface signals
`timescale 1ns/1ps
module ddr_hs_props
	import ddr_hs_pkg::*;
#(
	parameter int REFRESH_COUNT = REFRESH_INTERVAL_COUNT // request spacing
) (
	input wire logic       clk_sys,                 // main clock
	input wire logic       nrst,                    // async reset, low
	input wire logic [2:0] command,                 // user command
	input wire logic       burst_terminate,         // burst end strobe
	input wire logic       command_acknowledge,     // transfer running
	input wire logic       initialization_complete, // memory ready
	input wire logic       refresh_request,         // refresh pending
	input wire logic       refresh_complete_pulse   // refresh finished
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	logic [CNT_W-1:0] gap;       // clocks since last request rise
	logic             seen_req;  // a request rise was seen
	logic             term_seen; // terminate seen in this transfer
	// helper state for spacing and terminate tracking
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			gap       <= '0;
			seen_req  <= 1'h0;
			term_seen <= 1'h0;
		end else begin
			gap       <= $rose(refresh_request) ? CNT_W'(1) : gap + 1'h1;
			seen_req  <= seen_req | $rose(refresh_request);
			term_seen <= command_acknowledge & (term_seen | burst_terminate);
		end
	end
	// done pulse follows the refresh issue by the cycle time
	sequence s_done_soon;
		##[7:9] refresh_complete_pulse;
	endsequence
	// no acknowledge rise in the clocks after done
	sequence s_hold_off;
		(!$rose(command_acknowledge)) [*3];
	endsequence
	a_done_one_clock: assert property (
		refresh_complete_pulse |=> !refresh_complete_pulse) else $error("done pulse too long");
	a_request_until_done: assert property (
		$fell(refresh_request) |-> s_done_soon) else $error("no done after refresh issue");
	a_request_spacing: assert property (
		$rose(refresh_request) && seen_req |-> gap == REFRESH_COUNT)
		else $error("refresh request spacing wrong");
	a_init_sticky: assert property (
		initialization_complete |=> initialization_complete) else $error("init flag dropped");
	a_init_timing: assert property (
		command == CMD_INIT && !initialization_complete
		|-> ##[15:18] $rose(initialization_complete)) else $error("init flag late");
	a_no_early_ack: assert property (
		!initialization_complete |-> !command_acknowledge) else $error("ack before init");
	a_ack_after_done: assert property (
		refresh_complete_pulse |-> s_hold_off) else $error("ack too soon after refresh");
	a_ack_waits_term: assert property (
		$fell(command_acknowledge) |-> term_seen) else $error("ack fell without terminate");
	a_user_gap: assert property (
		refresh_complete_pulse |=> (command == CMD_NOP || $stable(command)) [*3])
		else $error("command too soon after refresh");
	a_user_terminates: assert property (
		$rose(refresh_request) && command_acknowledge && !term_seen
		|-> ##[0:20] burst_terminate) else $error("burst not ended for refresh");
endmodule : ddr_hs_props

// ==== bench/ddr_sdram_user_handshake_test.sv ====
// testbench: user end against controller end, plus a lone controller
// assumes a 100 MHz clock and a shortened refresh spacing
`timescale 1ns/1ps
module ddr_sdram_user_handshake_test;
	import ddr_hs_pkg::*;
	localparam int REF_N = 40; // short refresh spacing
	logic              clk_sys, nrst, req_valid, req_write, req_ready, rsp_valid; // stimulus
	logic [1:0]        bl_sel;     // burst length code
	logic [USER_W-1:0] rsp_rdata;  // read word
	logic [DATA_W-1:0] rd_half;    // changing memory half
	int                mismatches, checked, term_cnt; // counters
	logic [DATA_W-1:0] wr_half;    // half word toward memory
	logic              ref_cmd;    // auto-refresh strobe
	logic              pre_cmd;    // precharge strobe
	logic [1:0]        half_seen;  // low and high write halves seen
	int                pre_cnt;    // precharge strobes seen
	ddr_hs_if hs();   // joined pair
	ddr_hs_if hs_b(); // lone controller
	ddr_hs_controller #(.REFRESH_COUNT(REF_N)) ddr_hs_controller_inst (.clk_sys(clk_sys),
		.nrst(nrst), .hs(hs), .burst_length(bl_sel), .mem_read_half(rd_half),
		.mem_write_half(wr_half), .mem_refresh_cmd(ref_cmd), .mem_precharge(pre_cmd));
	ddr_hs_user ddr_hs_user_inst (.clk_sys(clk_sys), .nrst(nrst), .hs(hs),
		.burst_length(bl_sel), .req_valid(req_valid), .req_write(req_write),
		.req_addr(24'h000100), .req_wdata(32'h1234ABCD), .req_beats(4'h2),
		.req_ready(req_ready), .rsp_rdata(rsp_rdata), .rsp_valid(rsp_valid));
	ddr_hs_controller #(.REFRESH_COUNT(REF_N)) fault_ddr_hs_controller_inst (.clk_sys(clk_sys),
		.nrst(nrst), .hs(hs_b), .burst_length(bl_sel), .mem_read_half(rd_half),
		.mem_write_half(), .mem_refresh_cmd(), .mem_precharge());
	ddr_hs_props #(.REFRESH_COUNT(REF_N)) ddr_hs_props_inst (.clk_sys(clk_sys), .nrst(nrst),
		.command(hs.command), .burst_terminate(hs.burst_terminate),
		.command_acknowledge(hs.command_acknowledge),
		.initialization_complete(hs.initialization_complete),
		.refresh_request(hs.refresh_request),
		.refresh_complete_pulse(hs.refresh_complete_pulse));
	// free running clock
	initial begin
		clk_sys = 1'h0;
		forever #5 clk_sys = ~clk_sys;
	end
	// memory half counts up; terminate clocks are tallied
	always @(posedge clk_sys) begin
		rd_half <= rd_half + 1'h1;
		if (hs.burst_terminate === 1'h1) term_cnt <= term_cnt + 1;
		if (pre_cmd === 1'h1) pre_cnt <= pre_cnt + 1;
		if (wr_half === 16'hABCD) half_seen[0] <= 1'h1;
		if (wr_half === 16'h1234) half_seen[1] <= 1'h1;
	end
	task automatic check(input logic ok, input string what);
		checked++;
		if (ok !== 1'h1) begin
			mismatches++;
			$display("unexpected at %0t: %s", $time, what);
		end
	endtask : check
	task automatic expire(input int i, input int lim);
		if (i >= lim) begin
			check(1'h0, "wait ran out");
			conclude();
		end
	endtask : expire
	task automatic conclude;
		$display("mismatches %0d checked %0d", mismatches, checked);
		if (mismatches == 0 && checked > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : conclude
	// wait for the init flag
	task automatic t_init;
		int i;
		for (i = 0; i < 100 && hs.initialization_complete !== 1'h1; i++) @(negedge clk_sys);
		expire(i, 100);
		check(hs.command_acknowledge === 1'h0, "ack without command");
	endtask : t_init
	// one burst; count terminate clocks, check read half order
	task automatic t_burst(input logic wr, input logic [1:0] bl);
		int i, n0, p0, want;
		n0   = term_cnt;
		p0   = pre_cnt;
		want = (bl == BL_2) ? 1 : (bl == BL_8) ? 4 : 2;
		@(posedge clk_sys);
		bl_sel    <= bl;
		req_write <= wr;
		req_valid <= 1'h1;
		for (i = 0; i < 400 && req_ready !== 1'h1; i++) @(negedge clk_sys);
		expire(i, 400);
		@(posedge clk_sys);
		req_valid <= 1'h0;
		if (!wr) begin
			for (i = 0; i < 400 && rsp_valid !== 1'h1; i++) @(negedge clk_sys);
			expire(i, 400);
			check(rsp_rdata[USER_W-1:DATA_W] === rsp_rdata[DATA_W-1:0] + 1'h1, "half order");
		end
		for (i = 0; i < 400 && !(term_cnt - n0 >= want && hs.command_acknowledge === 1'h0);
			i++) @(negedge clk_sys);
		expire(i, 400);
		check(term_cnt - n0 == want, "terminate length wrong");
		check(pre_cnt - p0 == 1, "one precharge per burst");
		if (wr) check(half_seen === 2'h3, "write halves missing");
	endtask : t_burst
	// refresh completes with a single done pulse, tRFC after the issue
	task automatic t_refresh;
		int i;
		for (i = 0; i < 200 && ref_cmd !== 1'h1; i++) @(negedge clk_sys);
		expire(i, 200);
		for (i = 0; i < 20 && hs.refresh_complete_pulse !== 1'h1; i++) @(negedge clk_sys);
		check(i == RFC_COUNT, "done pulse spacing wrong");
		check(hs.refresh_request === 1'h0, "request high after refresh");
		@(negedge clk_sys);
		check(hs.refresh_complete_pulse === 1'h0, "done pulse too long");
	endtask : t_refresh
	// burst asked on the clock a pending refresh is issued, so it waits out the refresh
	task automatic t_busy;
		int i;
		for (i = 0; i < 200 && hs.refresh_request !== 1'h1; i++) @(negedge clk_sys);
		expire(i, 200);
		t_burst(1'h1, BL_4);
	endtask : t_busy
	// lone controller: early, reserved and short-terminated commands
	task automatic t_fault;
		int i, c;
		for (c = 0; c < 9; c++) begin
			if (c == 2 || c == 4 || c == 6) continue;
			@(posedge clk_sys);
			hs_b.command <= (c == 0) ? CMD_WRITE : 3'(c);
			@(posedge clk_sys);
			hs_b.command <= CMD_NOP;
			repeat (20) @(negedge clk_sys);
			check(hs_b.command_acknowledge === 1'h0, "refused code taken");
		end
		@(posedge clk_sys);
		hs_b.command <= CMD_INIT;
		@(posedge clk_sys);
		hs_b.command <= CMD_NOP;
		for (i = 0; i < 40 && hs_b.initialization_complete !== 1'h1; i++) @(negedge clk_sys);
		check(hs_b.initialization_complete === 1'h1, "init flag missing");
		@(posedge clk_sys);
		hs_b.command <= CMD_WRITE;
		for (i = 0; i < 40 && hs_b.command_acknowledge !== 1'h1; i++) @(negedge clk_sys);
		expire(i, 40);
		@(posedge clk_sys);
		hs_b.command         <= CMD_NOP;
		hs_b.burst_terminate <= 1'h1;
		@(posedge clk_sys);
		hs_b.burst_terminate <= 1'h0;
		repeat (8) @(negedge clk_sys);
		check(hs_b.command_acknowledge === 1'h1, "short terminate ended transfer");
		@(posedge clk_sys);
		hs_b.burst_terminate <= 1'h1;
		repeat (2) @(posedge clk_sys);
		hs_b.burst_terminate <= 1'h0;
		for (i = 0; i < 10 && hs_b.command_acknowledge !== 1'h0; i++) @(negedge clk_sys);
		check(i < 10, "ack stuck after terminate");
	endtask : t_fault
	// main sequence
	initial begin
		nrst = 1'h0;
		bl_sel = BL_4;
		req_valid = 1'h0;
		req_write = 1'h0;
		rd_half = '0;
		term_cnt = 0;
		pre_cnt = 0;
		half_seen = 2'h0;
		mismatches = 0;
		checked = 0;
		hs_b.command = CMD_NOP;
		hs_b.address = '0;
		hs_b.burst_terminate = 1'h0;
		hs_b.write_data = '0;
		repeat (5) @(posedge clk_sys);
		nrst <= 1'h1;
		t_init();
		t_burst(1'h1, BL_2);
		t_burst(1'h0, BL_2);
		t_burst(1'h1, BL_4);
		t_burst(1'h0, BL_4);
		t_burst(1'h1, BL_8);
		t_burst(1'h0, BL_8);
		t_refresh();
		t_busy();
		t_fault();
		conclude();
	end
endmodule : ddr_sdram_user_handshake_test
